/* hdl/route_pkg.sv */
// route_pkg: constants and types shared by the signal routing matrix.
// assumes 16-bit linear pcm samples and one frame strobe per 8 khz frame.
package route_pkg;
  localparam int sample_w = 16;
  localparam int sel_w = 5;
  localparam int num_src = 22;
  // source numbering
  localparam logic [4:0] src_silence = 5'h00;
  localparam logic [4:0] src_line_in = 5'h01;
  localparam logic [4:0] src_line_out = 5'h02;
  localparam logic [4:0] src_mic_in = 5'h03;
  localparam logic [4:0] src_spk_out = 5'h04;
  localparam logic [4:0] src_ser1_in = 5'h05;
  localparam logic [4:0] src_ser1_out = 5'h06;
  localparam logic [4:0] src_ser2_in = 5'h07;
  localparam logic [4:0] src_ser2_out = 5'h08;
  localparam logic [4:0] src_tone_main = 5'h09;
  localparam logic [4:0] src_tone_aux = 5'h0a;
  localparam logic [4:0] src_spk_acoustic = 5'h0b;
  localparam logic [4:0] src_spk_line = 5'h0c;
  localparam logic [4:0] src_rsvd_a = 5'h0d;
  localparam logic [4:0] src_atten = 5'h0e;
  localparam logic [4:0] src_line_echo = 5'h0f;
  localparam logic [4:0] src_rsvd_b = 5'h10;
  localparam logic [4:0] src_rsvd_c = 5'h11;
  localparam logic [4:0] src_eq1 = 5'h12;
  localparam logic [4:0] src_eq2 = 5'h13;
  localparam logic [4:0] src_gen1 = 5'h14;
  localparam logic [4:0] src_gen2 = 5'h15;
  localparam logic [4:0] src_last = 5'h15;
  localparam logic [15:0] silence_val = 16'h0000;
  localparam logic [15:0] sat_max = 16'h7fff;
  localparam logic [15:0] sat_min = 16'h8000;
  // number of unit inputs that have a selector; the summing nodes take four, two each
  localparam int num_in = 16;
  typedef logic [15:0] sample_type;
  typedef logic [4:0] sel_type;
endpackage

/* hdl/route_sum_if.sv */
// route_sum_if: carries the two operands and the sum of one summing node.
// assumes both ends share the matrix clock.
interface route_sum_if;
  logic [15:0] op_a;
  logic [15:0] op_b;
  logic [15:0] sum;
  modport node (input op_a, input op_b, output sum);
  modport user (output op_a, output op_b, input sum);
endinterface

/* hdl/signal_router.sv */
// signal_router: routes any numbered source to any function unit input.
// assumes sources and selectors are on sys_clk; frame_strobe is one cycle per frame.
////////////////////////////////////////////////////////////////////////////////
// Contract
// - every unit input has a selector that may pick any numbered source.
// - source zero gives constant silence, all-zero samples.
// - sources 1,2 are codec channel 1 line; 3,4 codec channel 2 mic/speaker.
// - sources 5 to 8 are serial voice channels 1 and 2 input/output.
// - sources 9,10 dual-tone outputs; 20,21 tone generator outputs.
// - 11,12 speakerphone, 14 attenuator, 15 line echo, 18,19 equalizers; 13,16,17 reserved.
// - any unit attaches to either codec or serial voice interface via selectors.
// - each function unit has its own independent enable.
// - speakerphone mic and line-in inputs are fed by a summing node.
module signal_router #(
  parameter int units = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // frame timing
  input wire logic frame_strobe,
  // source samples
  input wire route_pkg::sample_type codec_line_in,
  input wire route_pkg::sample_type codec_mic_in,
  input wire route_pkg::sample_type ser1_in,
  input wire route_pkg::sample_type ser2_in,
  input wire route_pkg::sample_type line_out_fb,
  input wire route_pkg::sample_type spk_out_fb,
  input wire route_pkg::sample_type ser1_out_fb,
  input wire route_pkg::sample_type ser2_out_fb,
  input wire route_pkg::sample_type tone_main,
  input wire route_pkg::sample_type tone_aux,
  input wire route_pkg::sample_type spk_acoustic,
  input wire route_pkg::sample_type spk_line,
  input wire route_pkg::sample_type atten_out,
  input wire route_pkg::sample_type line_echo_out,
  input wire route_pkg::sample_type eq1_out,
  input wire route_pkg::sample_type eq2_out,
  input wire route_pkg::sample_type gen1_out,
  input wire route_pkg::sample_type gen2_out,
  // selector codes, one per unit input, packed 5 bits each
  input wire logic [route_pkg::num_in*route_pkg::sel_w-1:0] sel_codes,
  // unit enables
  input wire logic [7:0] unit_enable,
  // routed unit inputs, packed 16 bits each; 0,1 and 2,3 are summing-node operand pairs
  output logic [route_pkg::num_in*route_pkg::sample_w-1:0] unit_in_r,
  output route_pkg::sample_type spk_mic_sum_r,
  output route_pkg::sample_type spk_line_sum_r,
  output logic [7:0] unit_active_r
);
  import route_pkg::*;

  // elaboration check: enable and active ports are fixed at eight bits, so other counts cannot be served
  if (units != 8) begin : g_units_chk
    $error("signal_router: units must be 8");
  end


  sample_type src [num_src];
  sample_type pick [num_in];
  sample_type pick_r [num_in];
  route_sum_if mic_if ();
  route_sum_if line_if ();

  ////////////////////////////////////////////////////////////////////////////
  // source table; reserved slots tie to silence
  always_comb begin
    src[src_silence] = silence_val;
    src[src_line_in] = codec_line_in;
    src[src_line_out] = line_out_fb;
    src[src_mic_in] = codec_mic_in;
    src[src_spk_out] = spk_out_fb;
    src[src_ser1_in] = ser1_in;
    src[src_ser1_out] = ser1_out_fb;
    src[src_ser2_in] = ser2_in;
    src[src_ser2_out] = ser2_out_fb;
    src[src_tone_main] = tone_main;
    src[src_tone_aux] = tone_aux;
    src[src_spk_acoustic] = spk_acoustic;
    src[src_spk_line] = spk_line;
    src[src_rsvd_a] = silence_val;
    src[src_atten] = atten_out;
    src[src_line_echo] = line_echo_out;
    src[src_rsvd_b] = silence_val;
    src[src_rsvd_c] = silence_val;
    src[src_eq1] = eq1_out;
    src[src_eq2] = eq2_out;
    src[src_gen1] = gen1_out;
    src[src_gen2] = gen2_out;
  end

  // decode one selector; codes past the table give silence
  function automatic sample_type route_one(input sel_type code, input sample_type tbl [num_src]);
    if (code > src_last) begin
      return silence_val;
    end
    return tbl[code];
  endfunction

  // every input may take any source, no restriction per input
  always_comb begin
    for (int i = 0; i < num_in; i++) begin
      pick[i] = route_one(sel_codes[i*sel_w +: sel_w], src);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // samples move once per frame; held between strobes so units see a stable value
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < num_in; i++) begin
        pick_r[i] <= silence_val;
      end
    end else if (frame_strobe) begin
      for (int i = 0; i < num_in; i++) begin
        pick_r[i] <= pick[i];
      end
    end
  end

  // flat output copy of the latched selections
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      unit_in_r <= '0;
    end else if (frame_strobe) begin
      for (int i = 0; i < num_in; i++) begin
        unit_in_r[i*sample_w +: sample_w] <= pick[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // summing nodes: mic takes inputs 0,1; line-in takes inputs 2,3
  assign mic_if.op_a = pick_r[0];
  assign mic_if.op_b = pick_r[1];
  assign line_if.op_a = pick_r[2];
  assign line_if.op_b = pick_r[3];

  sum_node u_mic_sum (
    .port_s(mic_if.node)
  );

  sum_node u_line_sum (
    .port_s(line_if.node)
  );

  // sums register one cycle after the frame latch; a disabled speakerphone sees silence
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      spk_mic_sum_r <= silence_val;
      spk_line_sum_r <= silence_val;
    end else if (unit_enable[0]) begin
      spk_mic_sum_r <= mic_if.sum;
      spk_line_sum_r <= line_if.sum;
    end else begin
      spk_mic_sum_r <= silence_val;
      spk_line_sum_r <= silence_val;
    end
  end

  // per-unit enables, each independent; the rest of the chip gates on these
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      unit_active_r <= 8'h00;
    end else begin
      unit_active_r <= unit_enable;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_silence_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    frame_strobe && sel_codes[4:0] == src_silence |=> unit_in_r[15:0] == silence_val)
    else $error("source zero did not give silence");
  a_reserved_silent: assert property (@(posedge sys_clk) disable iff (!rst_n)
    frame_strobe && (sel_codes[9:5] > src_last || sel_codes[9:5] == src_rsvd_a)
    |=> unit_in_r[31:16] == silence_val)
    else $error("reserved code did not give silence");
  a_line_in_route: assert property (@(posedge sys_clk) disable iff (!rst_n)
    frame_strobe && sel_codes[4:0] == src_line_in |=> unit_in_r[15:0] == $past(codec_line_in))
    else $error("codec line input not routed");
  a_mic_route: assert property (@(posedge sys_clk) disable iff (!rst_n)
    frame_strobe && sel_codes[14:10] == src_mic_in |=> unit_in_r[47:32] == $past(codec_mic_in))
    else $error("codec mic input not routed");
  a_serial_route: assert property (@(posedge sys_clk) disable iff (!rst_n)
    frame_strobe && sel_codes[4:0] == src_ser2_in |=> unit_in_r[15:0] == $past(ser2_in))
    else $error("serial channel 2 input not routed");
  a_tone_route: assert property (@(posedge sys_clk) disable iff (!rst_n)
    frame_strobe && sel_codes[79:75] == src_gen2 |=> unit_in_r[255:240] == $past(gen2_out))
    else $error("tone generator 2 not routed");
  a_eq_route: assert property (@(posedge sys_clk) disable iff (!rst_n)
    frame_strobe && sel_codes[4:0] == src_eq1 |=> unit_in_r[15:0] == $past(eq1_out))
    else $error("equalizer 1 not routed");
  a_hold_frame: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !frame_strobe |=> $stable(unit_in_r))
    else $error("routed sample changed between frames");
  a_sum_disabled: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !unit_enable[0] |=> spk_mic_sum_r == silence_val && spk_line_sum_r == silence_val)
    else $error("disabled speakerphone sum not silent");
  a_sum_add: assert property (@(posedge sys_clk) disable iff (!rst_n)
    frame_strobe && unit_enable[0] && sel_codes[9:5] == src_silence ##1 unit_enable[0] && !frame_strobe
    |=> spk_mic_sum_r == $past(unit_in_r[15:0]))
    else $error("mic sum with silent operand wrong");
  a_enable_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
    1'b1 |=> unit_active_r == $past(unit_enable))
    else $error("unit enable not tracked");
  // spot checks of further numbered sources on selector 0
  a_dual_tone_route: assert property (@(posedge sys_clk) disable iff (!rst_n)
    frame_strobe && sel_codes[4:0] == src_tone_main |=> unit_in_r[15:0] == $past(tone_main))
    else $error("dual-tone main output not routed");
  a_atten_route: assert property (@(posedge sys_clk) disable iff (!rst_n)
    frame_strobe && sel_codes[4:0] == src_atten |=> unit_in_r[15:0] == $past(atten_out))
    else $error("attenuator output not routed");
  c_frame: cover property (@(posedge sys_clk) disable iff (!rst_n) frame_strobe);
  c_serial_to_codec: cover property (@(posedge sys_clk) disable iff (!rst_n)
    frame_strobe && sel_codes[4:0] == src_ser1_in);
  c_sum_sat: cover property (@(posedge sys_clk) disable iff (!rst_n) spk_mic_sum_r == sat_max);
  c_sum_floor: cover property (@(posedge sys_clk) disable iff (!rst_n) spk_mic_sum_r == sat_min);
  c_reserved_code: cover property (@(posedge sys_clk) disable iff (!rst_n)
    frame_strobe && sel_codes[4:0] == src_rsvd_b);
endmodule

/* hdl/sum_node.sv */
// sum_node: saturating two-operand adder feeding one speakerphone input.
// assumes the operands come from the selector registers on the same clock.
module sum_node (
  // operands and result
  route_sum_if.node port_s
);
  import route_pkg::*;
  logic [16:0] wide;

  // sign-extend and add; saturate instead of wrapping, a wrap would click audibly
  always_comb begin
    wide = {port_s.op_a[15], port_s.op_a} + {port_s.op_b[15], port_s.op_b};
    if (wide[16] != wide[15]) begin
      port_s.sum = wide[16] ? sat_min : sat_max;
    end else begin
      port_s.sum = wide[15:0];
    end
  end
endmodule

/* verif/audio_signal_routing_matrix_tb.sv */
// audio_signal_routing_matrix_tb: self-checking bench for signal_router.
// assumes src_model feeds all sources; inputs change at the falling edge.
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; $display("[FAIL] %0t mismatch", $time); end end
module audio_signal_routing_matrix_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import route_pkg::*;
  logic sys_clk = 0, rst_n = 0, frame_strobe = 0;
  logic [10:0] base = 0;
  logic [79:0] sel_codes = 0;
  logic [7:0] unit_enable = 0;
  sample_type src [1:21];
  logic [255:0] unit_in_r;
  sample_type spk_mic_sum_r, spk_line_sum_r;
  logic [7:0] unit_active_r;
  int fails = 0, checked = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // clock and sources
  initial forever #2 sys_clk = ~sys_clk;
  src_model model (.base(base), .src(src));
  signal_router #(.units(8)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .frame_strobe(frame_strobe),
    .codec_line_in(src[1]), .line_out_fb(src[2]), .codec_mic_in(src[3]), .spk_out_fb(src[4]),
    .ser1_in(src[5]), .ser1_out_fb(src[6]), .ser2_in(src[7]), .ser2_out_fb(src[8]),
    .tone_main(src[9]), .tone_aux(src[10]), .spk_acoustic(src[11]), .spk_line(src[12]),
    .atten_out(src[14]), .line_echo_out(src[15]), .eq1_out(src[18]), .eq2_out(src[19]),
    .gen1_out(src[20]), .gen2_out(src[21]), .sel_codes(sel_codes), .unit_enable(unit_enable),
    .unit_in_r(unit_in_r), .spk_mic_sum_r(spk_mic_sum_r), .spk_line_sum_r(spk_line_sum_r),
    .unit_active_r(unit_active_r));
  ////////////////////////////////////////////////////////////////////////////////
  // expected sample for a code; reserved and out-of-range codes give silence
  function automatic sample_type expv(input logic [4:0] c);
    return (c == 0 || c == 13 || c == 16 || c == 17 || c > 21) ? silence_val : {base, c};
  endfunction
  // saturating add, worked out on 17 bits so overflow is visible
  function automatic sample_type sat(input sample_type a, input sample_type b);
    logic signed [16:0] t;
    t = $signed({a[15], a}) + $signed({b[15], b});
    return (t > 17'sd32767) ? sat_max : (t < -17'sd32768) ? sat_min : t[15:0];
  endfunction
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // one frame: strobe held over exactly one rising edge
  task automatic strobe(input logic [79:0] s);
    sel_codes = s;
    frame_strobe = 1;
    tick(1);
    frame_strobe = 0;
    tick(1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // every selector sees all 32 codes, each in a different frame
  task automatic t_sweep();
    logic [79:0] s;
    for (int c = 0; c < 32; c++) begin
      base = 11'(c * 37 + 1);
      for (int i = 0; i < 16; i++) s[5*i+:5] = 5'(c + i);
      strobe(s);
      for (int i = 0; i < 16; i++) `CHK(unit_in_r[16*i+:16], expv(5'(c + i)))
    end
    // routing stands until the next strobe even when sources move
    s = {48'h0, unit_in_r[31:0]};
    base = 11'h2aa;
    tick(3);
    `CHK(unit_in_r[31:0], s[31:0])
  endtask
  // back-to-back strobes, each frame routed in turn
  task automatic t_b2b();
    sel_codes = {16{5'h01}};
    frame_strobe = 1;
    tick(1);
    sel_codes = {16{5'h09}};
    `CHK(unit_in_r[15:0], expv(5'h01))
    tick(1);
    frame_strobe = 0;
    tick(1);
    for (int i = 0; i < 16; i++) `CHK(unit_in_r[16*i+:16], expv(5'h09))
  endtask
  // summing nodes: both saturation limits and a silent operand
  task automatic t_sum();
    logic [10:0] bases [3] = '{11'h3ff, 11'h400, 11'h005};
    logic [4:0] s1;
    unit_enable = 8'h01;
    for (int k = 0; k < 3; k++) begin
      base = bases[k];
      s1 = (k == 2) ? src_silence : src_line_out;
      strobe({60'h0, src_spk_out, src_mic_in, s1, src_line_in});
      tick(2);
      `CHK(spk_mic_sum_r, sat(expv(src_line_in), expv(s1)))
      `CHK(spk_line_sum_r, sat(expv(src_mic_in), expv(src_spk_out)))
    end
    unit_enable = 8'h00;
    tick(2);
    `CHK(spk_mic_sum_r, silence_val)
    `CHK(spk_line_sum_r, silence_val)
    // each enable moves alone
    for (int b = 0; b < 8; b++) begin
      unit_enable = 8'(1 << b);
      tick(2);
      `CHK(unit_active_r, 8'(1 << b))
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic stop_test();
    $display("fails=%0d checked=%0d", fails, checked);
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // main sequence: five cycles of reset, outputs zero meanwhile
  initial begin
    tick(5);
    `CHK(unit_in_r, 256'h0)
    `CHK(spk_mic_sum_r, silence_val)
    `CHK(spk_line_sum_r, silence_val)
    `CHK(unit_active_r, 8'h00)
    rst_n = 1;
    t_sweep();
    t_b2b();
    t_sum();
    stop_test();
  end
  // watchdog: the tests need well under 1000 cycles
  initial begin
    #20us;
    fails++;
    stop_test();
  end
endmodule

/* verif/src_model.sv */
// src_model: stands in for the codec, serial voice ports and units that feed the matrix.
// assumes the bench sets base between frames; every source is a level.
module src_model (
  // frame pattern from the bench
  input wire logic [10:0] base,
  // numbered sources 1 to 21
  output route_pkg::sample_type src [1:21]
);
  timeunit 1ns;
  timeprecision 1ps;
  import route_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  // each sample carries its own source number, so a misroute shows at once
  always_comb begin
    for (int k = 1; k < 22; k++) begin
      src[k] = {base, 5'(k)};
    end
  end
endmodule
